// ---- hw/udt_defines.vh ----
// register map, field positions and reset values of the up/down timer
`ifndef UDT_DEFINES_VH
`define UDT_DEFINES_VH

`define UDT_AW                32
`define UDT_DW                16

`define UDT_ADDR_MODE_SELECT  32'h0ffff5cb
`define UDT_ADDR_RUN_CLEAR    32'h0ffff5cc
`define UDT_ADDR_CAPCMP_SEL   32'hfffff5ca
`define UDT_ADDR_COUNTER      32'hfffff5c0
`define UDT_ADDR_FIRST_CMP    32'hfffff5c2
`define UDT_ADDR_SECOND_CMP   32'hfffff5c4
`define UDT_ADDR_FIRST_CC     32'hfffff5c6
`define UDT_ADDR_SECOND_CC    32'hfffff5c8

// timer_mode_select fields
`define UDT_OPERATION_MODE    7
`define UDT_OUTPUT_ENABLE     3
`define UDT_OUTPUT_LEVEL      2
`define UDT_SUBMODE_SELECT    0
`define UDT_MODE_MASK         8'h8d

// timer_run_and_clear_control fields
`define UDT_COUNT_ENABLE      6
`define UDT_RELOAD_ENABLE     3
`define UDT_GENERAL_CLEAR     2
`define UDT_CLEAR_SRC_HI      1
`define UDT_CLEAR_SRC_LO      0
`define UDT_RUN_MASK          8'h4f

// capture_compare_select fields
`define UDT_SECOND_CC_MODE    1
`define UDT_FIRST_CC_MODE     0
`define UDT_CAPCMP_MASK       8'h03

`define UDT_RESET_8           8'h00
`define UDT_RESET_16          16'h0000

// clear source codes
`define UDT_CLR_EXT_ONLY      2'h0
`define UDT_CLR_MATCH_ONLY    2'h1
`define UDT_CLR_EXT_OR_MATCH  2'h2
`define UDT_CLR_NONE          2'h3

// pin vector positions
`define UDT_PIN_COUNT         0
`define UDT_PIN_DIR           1
`define UDT_PIN_CLEAR         2
`define UDT_PIN_TRIG0         3
`define UDT_PIN_TRIG1         4

`endif

// ---- hw/udt_timer.v ----
// mode, clear, reload and capture/compare control of the 16-bit timer
`timescale 1ns/1ps
`include "udt_defines.vh"

module udt_timer (
   input  wire                 clk_i,
   input  wire                 sys_rst_i,
   input  wire [`UDT_AW-1:0]   addr_i,
   input  wire [`UDT_DW-1:0]   wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [`UDT_DW-1:0]   rdata_o,
   input  wire                 count_pulse_input_i,
   input  wire                 direction_input_i,
   input  wire                 external_clear_input_i,
   input  wire                 first_capture_trigger_i,
   input  wire                 second_capture_trigger_i,
   output reg                  timer_output_pin_o,
   output reg                  counting_down_o,
   output reg  [1:0]           capcmp_match_o
);

   reg  [7:0]  timer_mode_select;
   reg  [7:0]  timer_run_and_clear_control;
   reg  [7:0]  capture_compare_select;
   reg  [15:0] updown_counter;
   reg  [15:0] first_compare_register;
   reg  [15:0] second_compare_register;
   reg  [15:0] first_capture_compare;
   reg  [15:0] second_capture_compare;
   reg  [4:0]  pin_s1;
   reg  [4:0]  pin_s2;
   reg  [4:0]  pin_s3;
   reg  [4:0]  pin_f;
   reg  [4:0]  pin_q;
   reg         out_toggle;
   reg  [15:0] next_counter;
   reg  [15:0] next_rdata;
   reg  [15:0] next_first_cc;
   reg  [15:0] next_second_cc;
   reg  [1:0]  next_match;
   reg         next_out_toggle;
   reg         next_out_pin;

   function hit;
      input [`UDT_AW-1:0] a;
      input [`UDT_AW-1:0] b;
      input               s;
      begin
         hit = s && (a == b);
      end
   endfunction

   // mode decode
   wire encoder_updown_mode   = timer_mode_select[`UDT_OPERATION_MODE];
   wire encoder_submode_select = timer_mode_select[`UDT_SUBMODE_SELECT];
   wire output_enable_bit     = timer_mode_select[`UDT_OUTPUT_ENABLE];
   wire output_active_level_bit = timer_mode_select[`UDT_OUTPUT_LEVEL];
   wire count_enable_bit      = timer_run_and_clear_control[`UDT_COUNT_ENABLE];
   wire underflow_reload_enable =
      timer_run_and_clear_control[`UDT_RELOAD_ENABLE];
   wire general_clear_enable  =
      timer_run_and_clear_control[`UDT_GENERAL_CLEAR];
   wire [1:0] clear_source    = {
      timer_run_and_clear_control[`UDT_CLEAR_SRC_HI],
      timer_run_and_clear_control[`UDT_CLEAR_SRC_LO]};
   wire first_capcmp_mode     = capture_compare_select[`UDT_FIRST_CC_MODE];
   wire second_capcmp_mode    = capture_compare_select[`UDT_SECOND_CC_MODE];

   wire submode_a = encoder_updown_mode && !encoder_submode_select;
   wire submode_b = encoder_updown_mode && encoder_submode_select;

   // filtered pin events
   wire count_edge = pin_f[`UDT_PIN_COUNT] & ~pin_q[`UDT_PIN_COUNT];
   wire clear_edge = pin_f[`UDT_PIN_CLEAR] & ~pin_q[`UDT_PIN_CLEAR];
   wire trig0_edge = pin_f[`UDT_PIN_TRIG0] & ~pin_q[`UDT_PIN_TRIG0];
   wire trig1_edge = pin_f[`UDT_PIN_TRIG1] & ~pin_q[`UDT_PIN_TRIG1];

   // direction: up-only in timer mode, pin-driven in encoder mode
   wire count_up = !encoder_updown_mode || pin_f[`UDT_PIN_DIR];
   wire count_tick = count_enable_bit && count_edge;

   wire match_first  = (updown_counter == first_compare_register);
   wire match_second = (updown_counter == second_compare_register);

   wire ext_clear_used = submode_a && (clear_source == `UDT_CLR_EXT_ONLY ||
      clear_source == `UDT_CLR_EXT_OR_MATCH);
   wire match_clear_used = submode_a &&
      (clear_source == `UDT_CLR_MATCH_ONLY ||
       clear_source == `UDT_CLR_EXT_OR_MATCH);

   // clears on a compare match wait for the count edge
   wire clear_on_tick =
      (!encoder_updown_mode && general_clear_enable &&
       match_first) ||
      (match_clear_used && count_up && match_first) ||
      (submode_b && count_up && match_first) ||
      (submode_b && !count_up && match_second);

   wire underflow = !count_up && (updown_counter == `UDT_RESET_16);
   wire do_reload = submode_a && underflow_reload_enable &&
      underflow;

   // external clear ignores the run bit
   wire ext_clear = ext_clear_used && clear_edge;

   // shared pins lose their capture role
   wire trig0_ok = !encoder_updown_mode;
   wire trig1_ok = !ext_clear_used;

   wire wr_counter = hit(addr_i, `UDT_ADDR_COUNTER, wr_i);

   always @* begin
      next_counter = updown_counter;
      if (ext_clear) begin
         next_counter = `UDT_RESET_16;
      end else if (wr_counter && !count_enable_bit) begin
         // writes while running would race the count, so dropped
         next_counter = wdata_i;
      end else if (count_tick) begin
         if (clear_on_tick) begin
            next_counter = `UDT_RESET_16;
         end else if (do_reload) begin
            next_counter = first_compare_register;
         end else if (count_up) begin
            next_counter = updown_counter + 16'h0001;
         end else begin
            next_counter = updown_counter - 16'h0001;
         end
      end
   end

   always @* begin
      next_rdata = `UDT_RESET_16;
      if (hit(addr_i, `UDT_ADDR_MODE_SELECT, rd_i)) begin
         next_rdata = {8'h00, timer_mode_select};
      end else if (hit(addr_i, `UDT_ADDR_RUN_CLEAR, rd_i)) begin
         next_rdata = {8'h00, timer_run_and_clear_control};
      end else if (hit(addr_i, `UDT_ADDR_CAPCMP_SEL, rd_i)) begin
         next_rdata = {8'h00, capture_compare_select};
      end else if (hit(addr_i, `UDT_ADDR_COUNTER, rd_i)) begin
         next_rdata = updown_counter;
      end else if (hit(addr_i, `UDT_ADDR_FIRST_CMP, rd_i)) begin
         next_rdata = first_compare_register;
      end else if (hit(addr_i, `UDT_ADDR_SECOND_CMP, rd_i)) begin
         next_rdata = second_compare_register;
      end else if (hit(addr_i, `UDT_ADDR_FIRST_CC, rd_i)) begin
         next_rdata = first_capture_compare;
      end else if (hit(addr_i, `UDT_ADDR_SECOND_CC, rd_i)) begin
         next_rdata = second_capture_compare;
      end
   end

   // three-stage pin sampling; stage one feeds stage two only
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         pin_s3 <= 5'h00;
         pin_f  <= 5'h00;
         pin_q  <= 5'h00;
      end else begin
         pin_s1 <= {second_capture_trigger_i, first_capture_trigger_i,
                    external_clear_input_i, direction_input_i,
                    count_pulse_input_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
         pin_q  <= pin_f;
      end
   end

   // capture beats a software write in the same cycle
   always @* begin
      next_first_cc = first_capture_compare;
      if (!first_capcmp_mode && trig0_ok && trig0_edge) begin
         next_first_cc = updown_counter;
      end else if (hit(addr_i, `UDT_ADDR_FIRST_CC, wr_i)) begin
         next_first_cc = wdata_i;
      end
   end

   always @* begin
      next_second_cc = second_capture_compare;
      if (!second_capcmp_mode && trig1_ok && trig1_edge) begin
         next_second_cc = updown_counter;
      end else if (hit(addr_i, `UDT_ADDR_SECOND_CC, wr_i)) begin
         next_second_cc = wdata_i;
      end
   end

   // compare-mode registers report a match only on a count edge that finds the counter equal to them
   always @* begin
      next_match = 2'h0;
      if (first_capcmp_mode && count_tick &&
          updown_counter == first_capture_compare) begin
         next_match[0] = 1'b1;
      end
      if (second_capcmp_mode && count_tick &&
          updown_counter == second_capture_compare) begin
         next_match[1] = 1'b1;
      end
   end

   // output toggles on first compare match in timer mode
   always @* begin
      next_out_toggle = out_toggle;
      if (encoder_updown_mode || !output_enable_bit) begin
         next_out_toggle = 1'b0;
      end else if (count_tick && match_first) begin
         next_out_toggle = ~out_toggle;
      end
   end

   // idle level equals the level bit: low when active high
   always @* begin
      next_out_pin = output_active_level_bit;
      if (!encoder_updown_mode && output_enable_bit) begin
         next_out_pin = out_toggle ^ output_active_level_bit;
      end
   end

   // control writes are taken as given; prohibited mixes and
   // writes while counting are left to software, no guard here
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         timer_mode_select <= `UDT_RESET_8;
      end else if (hit(addr_i, `UDT_ADDR_MODE_SELECT, wr_i)) begin
         timer_mode_select <= wdata_i[7:0] & `UDT_MODE_MASK;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         timer_run_and_clear_control <= `UDT_RESET_8;
      end else if (hit(addr_i, `UDT_ADDR_RUN_CLEAR, wr_i)) begin
         timer_run_and_clear_control <= wdata_i[7:0] & `UDT_RUN_MASK;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         capture_compare_select <= `UDT_RESET_8;
      end else if (hit(addr_i, `UDT_ADDR_CAPCMP_SEL, wr_i)) begin
         capture_compare_select <= wdata_i[7:0] & `UDT_CAPCMP_MASK;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         first_compare_register <= `UDT_RESET_16;
      end else if (hit(addr_i, `UDT_ADDR_FIRST_CMP, wr_i)) begin
         first_compare_register <= wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         second_compare_register <= `UDT_RESET_16;
      end else if (hit(addr_i, `UDT_ADDR_SECOND_CMP, wr_i)) begin
         second_compare_register <= wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         first_capture_compare <= `UDT_RESET_16;
      end else begin
         first_capture_compare <= next_first_cc;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         second_capture_compare <= `UDT_RESET_16;
      end else begin
         second_capture_compare <= next_second_cc;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         updown_counter <= `UDT_RESET_16;
      end else begin
         updown_counter <= next_counter;
      end
   end

   // read data stands one cycle only, zero otherwise
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= `UDT_RESET_16;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         capcmp_match_o <= 2'h0;
      end else begin
         capcmp_match_o <= next_match;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         counting_down_o <= 1'b0;
      end else begin
         counting_down_o <= !count_up;
      end
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         out_toggle <= 1'b0;
      end else begin
         out_toggle <= next_out_toggle;
      end
   end

   // pin reset value matches the idle level of the reset mode
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         timer_output_pin_o <= 1'b0;
      end else begin
         timer_output_pin_o <= next_out_pin;
      end
   end

endmodule // udt_timer

// ---- tb/tb.sv ----
// self-checking bench for the up/down timer control block
`timescale 1ns/1ps
`include "udt_defines.vh"
module tb;
   reg         clk_i = 1'h0;
   reg         sys_rst_i = 1'h1;
   reg  [31:0] addr_i = 32'h0;
   reg  [15:0] wdata_i = 16'h0;
   reg         wr_i = 1'h0;
   reg         rd_i = 1'h0;
   wire [15:0] rdata_o;
   wire [4:0]  pin;
   wire        tout;
   wire        down;
   wire [1:0]  match;
   reg         seen;
   reg  [15:0] v;
   reg  [15:0] run_val = 16'h0000;
   integer     num_errors = 0;
   integer     check_count = 0;
   udt_pins pins (.clk_i(clk_i), .pins_o(pin));
   udt_timer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .count_pulse_input_i(pin[`UDT_PIN_COUNT]),
      .direction_input_i(pin[`UDT_PIN_DIR]),
      .external_clear_input_i(pin[`UDT_PIN_CLEAR]),
      .first_capture_trigger_i(pin[`UDT_PIN_TRIG0]),
      .second_capture_trigger_i(pin[`UDT_PIN_TRIG1]),
      .timer_output_pin_o(tout), .counting_down_o(down),
      .capcmp_match_o(match));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (match[0])
         seen <= 1'h1;
   task check(input [15:0] s, input [15:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
         end
      end
   endtask
   task wr(input [31:0] a, input [15:0] d);
      begin
         @(posedge clk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'h1;
         @(posedge clk_i);
         wr_i <= 1'h0;
      end
   endtask
   task chk(input [31:0] a, input [15:0] e);
      begin
         @(posedge clk_i);
         addr_i <= a;
         rd_i <= 1'h1;
         @(posedge clk_i);
         rd_i <= 1'h0;
         #1 check(rdata_o, e);
      end
   endtask
   // stop before touching mode or counter, start last
   task cfg(input [15:0] m, input [15:0] c, input [15:0] r);
      begin
         wr(`UDT_ADDR_RUN_CLEAR, run_val & 16'hffbf);
         wr(`UDT_ADDR_MODE_SELECT, m);
         wr(`UDT_ADDR_COUNTER, c);
         wr(`UDT_ADDR_RUN_CLEAR, r);
         run_val = r;
      end
   endtask
   task t_regs;
      begin
         chk(`UDT_ADDR_MODE_SELECT, 16'h0000);
         chk(`UDT_ADDR_CAPCMP_SEL, 16'h0000);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         wr(`UDT_ADDR_MODE_SELECT, 16'hffff);
         chk(`UDT_ADDR_MODE_SELECT, 16'h008d);
         wr(`UDT_ADDR_CAPCMP_SEL, 16'hffff);
         chk(`UDT_ADDR_CAPCMP_SEL, 16'h0003);
         cfg(16'h0000, 16'h0000, 16'h0000);
         wr(`UDT_ADDR_CAPCMP_SEL, 16'h0000);
         chk(32'hfffff5d0, 16'h0000);
         $display("t_regs done");
      end
   endtask
   task t_gp;
      begin
         wr(`UDT_ADDR_FIRST_CMP, 16'h0003);
         cfg(16'h0000, 16'h0000, 16'h0047);
         pins.pulse(`UDT_PIN_COUNT, 5);
         chk(`UDT_ADDR_COUNTER, 16'h0001);
         cfg(16'h0000, 16'h0001, 16'h0040);
         pins.pulse(`UDT_PIN_CLEAR, 1);
         pins.pulse(`UDT_PIN_COUNT, 3);
         chk(`UDT_ADDR_COUNTER, 16'h0004);
         wr(`UDT_ADDR_RUN_CLEAR, 16'h0000);
         pins.pulse(`UDT_PIN_COUNT, 2);
         chk(`UDT_ADDR_COUNTER, 16'h0004);
         $display("t_gp done");
      end
   endtask
   task t_enc_a;
      begin
         wr(`UDT_ADDR_FIRST_CMP, 16'h0010);
         pins.level(`UDT_PIN_DIR, 1'h0);
         cfg(16'h0080, 16'h0001, 16'h0048);
         pins.pulse(`UDT_PIN_COUNT, 2);
         chk(`UDT_ADDR_COUNTER, 16'h0010);
         check({15'h0000, down}, 16'h0001);
         pins.pulse(`UDT_PIN_CLEAR, 1);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         wr(`UDT_ADDR_RUN_CLEAR, 16'h0008);
         wr(`UDT_ADDR_COUNTER, 16'h0005);
         pins.pulse(`UDT_PIN_CLEAR, 1);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         cfg(16'h0080, 16'h0007, 16'h0043);
         pins.pulse(`UDT_PIN_CLEAR, 1);
         chk(`UDT_ADDR_COUNTER, 16'h0007);
         cfg(16'h0080, 16'h0007, 16'h0042);
         pins.pulse(`UDT_PIN_CLEAR, 1);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         cfg(16'h0080, 16'h0011, 16'h0041);
         pins.pulse(`UDT_PIN_COUNT, 2);
         chk(`UDT_ADDR_COUNTER, 16'h000f);
         pins.level(`UDT_PIN_DIR, 1'h1);
         cfg(16'h0080, 16'h000e, 16'h0041);
         pins.pulse(`UDT_PIN_COUNT, 3);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         $display("t_enc_a done");
      end
   endtask
   task t_enc_b;
      begin
         wr(`UDT_ADDR_FIRST_CMP, 16'h0005);
         wr(`UDT_ADDR_SECOND_CMP, 16'h0002);
         cfg(16'h0081, 16'h0004, 16'h0043);
         pins.pulse(`UDT_PIN_COUNT, 2);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         pins.level(`UDT_PIN_DIR, 1'h0);
         cfg(16'h0081, 16'h0003, 16'h004b);
         pins.pulse(`UDT_PIN_COUNT, 2);
         chk(`UDT_ADDR_COUNTER, 16'h0000);
         pins.pulse(`UDT_PIN_COUNT, 1);
         chk(`UDT_ADDR_COUNTER, 16'hffff);
         $display("t_enc_b done");
      end
   endtask
   task t_out;
      begin
         wr(`UDT_ADDR_FIRST_CMP, 16'h0002);
         cfg(16'h0008, 16'h0002, 16'h0040);
         pins.pulse(`UDT_PIN_COUNT, 1);
         check({15'h0000, tout}, 16'h0001);
         cfg(16'h000c, 16'h0000, 16'h0000);
         check({15'h0000, tout}, 16'h0000);
         cfg(16'h008c, 16'h0000, 16'h0000);
         check({15'h0000, tout}, 16'h0001);
         cfg(16'h0004, 16'h0000, 16'h0000);
         check({15'h0000, tout}, 16'h0001);
         $display("t_out done");
      end
   endtask
   task t_cc;
      begin
         cfg(16'h0000, 16'h0033, 16'h0000);
         pins.pulse(`UDT_PIN_TRIG0, 1);
         chk(`UDT_ADDR_FIRST_CC, 16'h0033);
         cfg(16'h0080, 16'h0044, 16'h0000);
         pins.pulse(`UDT_PIN_TRIG0, 1);
         pins.pulse(`UDT_PIN_TRIG1, 1);
         chk(`UDT_ADDR_FIRST_CC, 16'h0033);
         chk(`UDT_ADDR_SECOND_CC, 16'h0000);
         cfg(16'h0000, 16'h0006, 16'h0000);
         wr(`UDT_ADDR_CAPCMP_SEL, 16'h0003);
         wr(`UDT_ADDR_FIRST_CC, 16'h0006);
         seen = 1'h0;
         wr(`UDT_ADDR_RUN_CLEAR, 16'h0040);
         pins.pulse(`UDT_PIN_COUNT, 1);
         check({15'h0000, seen}, 16'h0001);
         $display("t_cc done");
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", check_count, num_errors);
         if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      t_regs;
      t_gp;
      t_enc_a;
      t_enc_b;
      t_out;
      t_cc;
      finish_test;
   end
   initial begin
      #(100 * 20000);
      num_errors = num_errors + 1;
      finish_test;
   end
endmodule // tb

// ---- tb/udt_checker.sv ----
// assertion checker bound to the up/down timer ports
`timescale 1ns/1ps
`include "udt_defines.vh"
module udt_checker (
   input  wire                 clk_i,
   input  wire                 sys_rst_i,
   input  wire [`UDT_AW-1:0]   addr_i,
   input  wire [`UDT_DW-1:0]   wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   input  wire [`UDT_DW-1:0]   rdata_o,
   input  wire                 count_pulse_input_i,
   input  wire                 direction_input_i,
   input  wire                 external_clear_input_i,
   input  wire                 first_capture_trigger_i,
   input  wire                 second_capture_trigger_i,
   input  wire                 timer_output_pin_o,
   input  wire                 counting_down_o,
   input  wire [1:0]           capcmp_match_o
);
   // shadow copies, since the checker cannot see the register file
   reg [7:0] mode;
   reg [7:0] run;
   reg [7:0] ccs;
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode <= 8'h00;
         run  <= 8'h00;
         ccs  <= 8'h00;
      end else if (wr_i) begin
         if (addr_i == `UDT_ADDR_MODE_SELECT)
            mode <= wdata_i[7:0] & `UDT_MODE_MASK;
         if (addr_i == `UDT_ADDR_RUN_CLEAR)
            run <= wdata_i[7:0] & `UDT_RUN_MASK;
         if (addr_i == `UDT_ADDR_CAPCMP_SEL)
            ccs <= wdata_i[7:0] & `UDT_CAPCMP_MASK;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // three quiet cycles cover the registered output stage
   sequence s_enc;
      (mode[7] && $stable(mode)) [*3];
   endsequence
   sequence s_gp;
      (!mode[7] && $stable(mode)) [*3];
   endsequence
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("read data not zero outside read slot");
   AST_MODE_READ: assert property (
      rd_i && addr_i == `UDT_ADDR_MODE_SELECT
      |=> rdata_o == {8'h00, mode}) else $error("mode readback wrong");
   AST_RUN_READ: assert property (
      rd_i && addr_i == `UDT_ADDR_RUN_CLEAR
      |=> rdata_o == {8'h00, run}) else $error("run readback wrong");
   AST_MATCH_PULSE: assert property (|capcmp_match_o
      |=> capcmp_match_o == 2'h0) else $error("match pulse too long");
   AST_MATCH_CMP: assert property (
      (capcmp_match_o & ~ccs[1:0]) == 2'h0)
      else $error("match flagged on a capture register");
   AST_ENC_OUT: assert property (
      s_enc |-> timer_output_pin_o == mode[2])
      else $error("encoder mode output not inactive");
   AST_OUT_OFF: assert property (s_gp ##0 !mode[3]
      |-> timer_output_pin_o == mode[2]) else $error("disabled output moved");
   AST_GP_UP: assert property (s_gp |-> !counting_down_o)
      else $error("timer mode counts down");
endmodule // udt_checker

bind udt_timer udt_checker chk (.*);

// ---- tb/udt_pins.sv ----
// far-side pin model: count, direction, clear and trigger pins
`timescale 1ns/1ps
module udt_pins (
   input  wire       clk_i,
   output reg  [4:0] pins_o
);
   initial pins_o = 5'h00;
   // 4 cycles per level, above the 2-cycle filter minimum
   task pulse(input integer b, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clk_i);
            pins_o[b] <= 1'h1;
            repeat (4) @(posedge clk_i);
            pins_o[b] <= 1'h0;
            repeat (4) @(posedge clk_i);
         end
      end
   endtask
   task level(input integer b, input reg v);
      begin
         @(posedge clk_i);
         pins_o[b] <= v;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule // udt_pins
